/* rtl/bhs_pkg.sv */
// Constants, types and helpers shared by the boot sequencer
package bhs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_W = 16;
  localparam int CNT_W  = 13;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // Cycles the device needs to complete a power-on reset internally
  localparam logic [CNT_W-1:0] POR_CYCLES = 13'h1830;
  localparam logic [CNT_W-1:0] POR_LAST   = POR_CYCLES - 13'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE    = 13'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 13'h0000;

  // ----------------------------------------------------------------
  // Boot memory and instruction decode
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BOOT_ROM_BASE = 16'h0000;
  localparam int                OP_MSB        = 31;
  localparam int                OP_LSB        = 28;
  localparam logic [3:0]        RSVD_OP       = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Gray codes along hold -> por -> fetch -> decode -> init -> done
  typedef enum logic [2:0] {
    BHS_HOLD     = 3'h0,
    BHS_POR      = 3'h1,
    BHS_FETCH    = 3'h3,
    BHS_DECODE   = 3'h2,
    BHS_CPU_INIT = 3'h6,
    BHS_DONE     = 3'h7,
    BHS_HALT     = 3'h5
  } bhs_state_t;

  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] addr;
  } bhs_rom_req_t;

  typedef struct packed {
    logic              ack;
    logic [WORD_W-1:0] data;
  } bhs_rom_rsp_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } bhs_bus_t;

  typedef struct packed {
    logic boot_from_rom;
    logic release_cpu;
  } bhs_cpu_ctl_t;

  typedef struct packed {
    logic done;
    logic halted;
  } bhs_status_t;

  typedef struct packed {
    bhs_state_t        st;
    logic [CNT_W-1:0]  cnt;
    logic              warm;
    bhs_bus_t          bus;
    logic [WORD_W-1:0] dec_word;
    bhs_rom_req_t      rom;
    bhs_cpu_ctl_t      cpu;
    bhs_status_t       stat;
  } bhs_regs_t;

  localparam bhs_regs_t REGS_RESET = '0;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic is_reserved(input logic [WORD_W-1:0] word);
    is_reserved = (word[OP_MSB:OP_LSB] == RSVD_OP);
  endfunction

endpackage : bhs_pkg

/* rtl/bhs_boot_seq.sv */
// Boot sequencer with reset-recoverable boot hang behaviour
//
// Functional notes
// - On reset release, boot logic starts and sets processor to run from boot ROM.
// - Unset bus at power-on may decode as reserved; boot then halts until a pin reset.
// - After a halt the bus is valid; a POR or warm reset then boots normally.
// - A power-on reset takes a fixed cycle count on top of the boot run.
module bhs_boot_seq
(
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       por_rst_n,
  input  wire logic                       warm_rst_n,
  input  wire logic [bhs_pkg::WORD_W-1:0] bus_noise,
  input  wire bhs_pkg::bhs_rom_rsp_t      rom_rsp,
  output bhs_pkg::bhs_rom_req_t           rom_req,
  output bhs_pkg::bhs_cpu_ctl_t           cpu_ctl,
  output bhs_pkg::bhs_status_t            status
);
  import bhs_pkg::*;

  // ----------------------------------------------------------------
  // Supply reset synchroniser
  // ----------------------------------------------------------------
  // rst_n is the supply power-up reset; it alone clears the boot bus,
  // so a pin reset (POR or warm) leaves the fetched word in place.
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bhs_regs_t r;
  bhs_regs_t next_r;
  logic      pin_reset;

  assign pin_reset = !por_rst_n || !warm_rst_n;

  always_comb
  begin
    next_r = r;
    if (pin_reset)
    begin
      // A pin reset aborts any sequence, including a halt
      // secondary reset recovers
      next_r.st       = BHS_HOLD;
      next_r.warm     = por_rst_n;
      next_r.cnt      = CNT_ZERO;
      next_r.rom.req  = 1'b0;
      next_r.cpu      = '0;
      next_r.stat     = '0;
    end
    else
    begin
      case (r.st)
        BHS_HOLD:
        begin
          if (r.warm)
          begin
            next_r.st       = BHS_FETCH;
            next_r.rom.req  = 1'b1;
            next_r.rom.addr = BOOT_ROM_BASE;
          end
          else
          begin
            next_r.st  = BHS_POR;
            next_r.cnt = CNT_ZERO;
          end
        end
        BHS_POR:
        begin
          if (r.cnt == POR_LAST)
          begin
            next_r.st       = BHS_FETCH;
            next_r.rom.req  = 1'b1;
            next_r.rom.addr = BOOT_ROM_BASE;
          end
          else
          begin
            next_r.cnt = r.cnt + CNT_ONE;
          end
        end
        BHS_FETCH:
        begin
          // Decoder sees the bus as it stood before this fetch lands
          // stale bus decoded
          if (rom_rsp.ack)
          begin
            next_r.rom.req   = 1'b0;
            next_r.dec_word  = r.bus.valid ? r.bus.data : bus_noise;
            next_r.bus.data  = rom_rsp.data;
            next_r.bus.valid = 1'b1;
            next_r.st        = BHS_DECODE;
          end
        end
        BHS_DECODE:
        begin
          if (is_reserved(r.dec_word))
          begin
            next_r.st          = BHS_HALT;
            next_r.stat.halted = 1'b1;
          end
          else
          begin
            next_r.st                = BHS_CPU_INIT;
            next_r.cpu.boot_from_rom = 1'b1;
          end
        end
        BHS_CPU_INIT:
        begin
          // Processor now takes over user boot mode selection
          next_r.cpu.release_cpu = 1'b1;
          next_r.stat.done       = 1'b1;
          next_r.st              = BHS_DONE;
        end
        BHS_DONE:
        begin
          next_r.st = BHS_DONE;
        end
        BHS_HALT:
        begin
          // Stuck until a pin reset; nothing inside can leave this
          next_r.st = BHS_HALT;
        end
        default:
        begin
          next_r.st = BHS_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      r <= REGS_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rom_req = r.rom;
  assign cpu_ctl = r.cpu;
  assign status  = r.stat;

endmodule // bhs_boot_seq

/* tb/bhs_chk_sva.sv */
// Port checker for the boot sequencer
module bhs_chk
(
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  por_rst_n,
  input wire logic                  warm_rst_n,
  input wire bhs_pkg::bhs_rom_rsp_t rom_rsp,
  input wire bhs_pkg::bhs_rom_req_t rom_req,
  input wire bhs_pkg::bhs_cpu_ctl_t cpu_ctl,
  input wire bhs_pkg::bhs_status_t  status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Decode lands two edges after the acknowledged fetch
  sequence s_decode;
    !rom_req.req ##1 (cpu_ctl.boot_from_rom ^ status.halted);
  endsequence
  chk_rom_base: assert property (rom_req.req |-> rom_req.addr == 16'h0000)
    else $error("fetch not from boot rom base");
  chk_cpu_order: assert property ($rose(cpu_ctl.release_cpu) |-> $past(cpu_ctl.boot_from_rom) && status.done)
    else $error("processor released before rom setup");
  chk_halt_excl: assert property (status.halted |-> !cpu_ctl.boot_from_rom && !status.done)
    else $error("halt and boot together");
  chk_halt_stay: assert property (status.halted && por_rst_n && warm_rst_n |=> status.halted)
    else $error("halt left without pin reset");
  chk_pin_abort: assert property (!por_rst_n || !warm_rst_n |=> !rom_req.req && !status.halted && !status.done)
    else $error("pin reset did not clear outputs");
  chk_warm_fetch: assert property ($rose(warm_rst_n) && por_rst_n |=> rom_req.req)
    else $error("warm release did not fetch");
  chk_fetch_decode: assert property (rom_req.req && rom_rsp.ack && por_rst_n && warm_rst_n |=> s_decode)
    else $error("decode timing wrong");
endmodule // bhs_chk

bind bhs_boot_seq bhs_chk u_chk (.clock(clock), .rst_n(rst_n), .por_rst_n(por_rst_n),
  .warm_rst_n(warm_rst_n), .rom_rsp(rom_rsp), .rom_req(rom_req), .cpu_ctl(cpu_ctl), .status(status));

/* tb/bhs_rst_src.sv */
// Board reset source giving one timed secondary reset
module bhs_rst_src #(parameter int WAIT = 21192, parameter int LOW = 8)
(
  input  wire logic clock,
  input  wire logic power_ok,
  input  wire logic use_warm,
  output logic      por_rst_n,
  output logic      warm_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt;
  logic pulse;
  // Long released span, then short low
  // One pulse, then released for good
  always_ff @(negedge clock or negedge power_ok)
  begin
    if (!power_ok)
      cnt <= 0;
    else if (cnt < WAIT + LOW)
      cnt <= cnt + 1;
  end
  assign pulse      = power_ok && cnt >= WAIT && cnt < WAIT + LOW;
  assign por_rst_n  = power_ok && !(pulse && !use_warm);
  assign warm_rst_n = !(pulse && use_warm);
endmodule // bhs_rst_src

/* tb/bhs_boot_seq_test.sv */
// Self-checking bench for the boot sequencer
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module bhs_boot_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bhs_pkg::*;
  logic         clock = 0;
  logic         rst_n = 0;
  logic         power_ok = 0;
  logic         use_warm = 1;
  logic [31:0]  bus_noise = 32'hF000_0000;
  logic         por_rst_n;
  logic         warm_rst_n;
  bhs_rom_rsp_t rom_rsp = '0;
  bhs_rom_req_t rom_req;
  bhs_cpu_ctl_t cpu_ctl;
  bhs_status_t  status;
  int           bad_count = 0;
  int           tests_run = 0;
  // The POR path spends one edge leaving hold, then the full internal count
  localparam int POR_EDGES  = int'(POR_CYCLES) + 1;
  localparam int WARM_EDGES = 1;
  always #5 clock = ~clock;
  bhs_rst_src u_src (.clock(clock), .power_ok(power_ok), .use_warm(use_warm),
    .por_rst_n(por_rst_n), .warm_rst_n(warm_rst_n));
  bhs_boot_seq DUT (.clock(clock), .rst_n(rst_n), .por_rst_n(por_rst_n), .warm_rst_n(warm_rst_n),
    .bus_noise(bus_noise), .rom_rsp(rom_rsp), .rom_req(rom_req), .cpu_ctl(cpu_ctl), .status(status));
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Counts edges from pin release to fetch, answers it, judges the outcome
  task automatic boot(input int n_exp, input logic halt_exp);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (rom_req.req !== 1'b1 && n < 7000);
    `CHK("start", n_exp, n)
    `CHK("addr", BOOT_ROM_BASE, rom_req.addr)
    rom_rsp = '{1'b1, 32'h1234_5678};
    @(negedge clock);
    rom_rsp.ack = 1'b0;
    repeat (3) @(negedge clock);
    `CHK("halted", halt_exp, status.halted)
    `CHK("rom", !halt_exp, cpu_ctl.boot_from_rom)
    `CHK("done", !halt_exp, status.done)
    `CHK("release", !halt_exp, cpu_ctl.release_cpu)
  endtask
  task automatic await_pulse();
    int n;
    n = 0;
    // Pins move on the falling edge; looking at the rising edge avoids racing the model
    while (por_rst_n && warm_rst_n && n < 30000)
    begin
      @(posedge clock);
      n++;
    end
    if (n >= 30000)
      bad_count++;
    while (!(por_rst_n && warm_rst_n)) @(posedge clock);
  endtask
  task automatic test_halt_warm();
    power_ok = 1;
    boot(POR_EDGES, 1'b1);
    await_pulse();
    boot(WARM_EDGES, 1'b0);
    $display("test halt_warm finished");
  endtask
  task automatic test_por_again();
    power_ok = 0;
    use_warm = 0;
    @(negedge clock);
    power_ok = 1;
    boot(POR_EDGES, 1'b0);
    await_pulse();
    boot(POR_EDGES, 1'b0);
    $display("test por_again finished");
  endtask
  // Supply reset in mid-run clears the boot bus, so the reserved noise halts again
  task automatic test_supply_again();
    rst_n = 0;
    power_ok = 0;
    repeat (4) @(negedge clock);
    rst_n = 1;
    repeat (4) @(negedge clock);
    power_ok = 1;
    boot(POR_EDGES, 1'b1);
    $display("test supply_again finished");
  endtask
  initial
  begin
    repeat (4) @(negedge clock);
    rst_n = 1;
    repeat (4) @(negedge clock);
    test_halt_warm();
    test_por_again();
    test_supply_again();
    conclude();
  end
  initial
  begin
    repeat (90000) @(posedge clock);
    bad_count++;
    conclude();
  end
endmodule // bhs_boot_seq_test
